// *** common/bfap_map.svh ***
`ifndef BFAP_MAP_SVH
`define BFAP_MAP_SVH
`define BFAP_OFS_LOCK 8'h00
`define BFAP_OFS_FUSE 8'h04
`define BFAP_OFS_CFG 8'h08
`define BFAP_OFS_CTRL 8'h0C
`define BFAP_OFS_STAT 8'h10
`define BFAP_LOCK_GEN_LO 0
`define BFAP_LOCK_GEN_HI 1
`define BFAP_LOCK_APP_LO 2
`define BFAP_LOCK_APP_HI 3
`define BFAP_LOCK_BOOT_LO 4
`define BFAP_LOCK_BOOT_HI 5
`define BFAP_LOCK_RESET 6'h3F
`define BFAP_FUSE_RESET 1'h1
`define BFAP_CFG_IVEC_BIT 16
`define BFAP_CTRL_ERASE_BIT 0
`define BFAP_STAT_RD_DENY 0
`define BFAP_STAT_WR_DENY 1
`define BFAP_STAT_APP_STORE 2
`endif

// *** common/bfap_pkg.sv ***
package bfap_pkg;
   localparam int BFAP_AW = 16;
   typedef enum logic [2:0] {
      BFAP_OP_LOAD,
      BFAP_OP_FILL,
      BFAP_OP_ERASE,
      BFAP_OP_WRITE,
      BFAP_OP_LOCKSET
   } bfap_op_t;
   typedef struct packed {
      logic valid;
      bfap_op_t op;
      logic [BFAP_AW-1:0] pc;
      logic [BFAP_AW-1:0] addr;
      logic [7:0] data;
   } bfap_req_t;
   typedef struct packed {
      logic done;
      logic granted;
      logic denied;
      logic prog_start;
      bfap_op_t op;
   } bfap_resp_t;
   typedef struct packed {
      logic [5:0] lock;
      logic fuse;
      logic [BFAP_AW-1:0] bound;
      logic ivec_boot;
      logic [2:0] stat;
      bfap_resp_t resp;
      logic irq_mask;
      logic [BFAP_AW-1:0] rst_vec;
      logic ack;
      logic [31:0] rdat;
   } bfap_state_t;
endpackage

// *** verilog/bfap_top.sv ***
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "bfap_map.svh"
module bfap_top import bfap_pkg::*; #(
   parameter logic [BFAP_AW-1:0] BOUND_RESET = 16'h1C00
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // external programming mode
   input wire logic ext_prog_mode,
   // cpu request and answer
   input wire bfap_req_t cpu_req,
   output bfap_resp_t cpu_resp,
   // section state to the core
   output logic irq_mask,
   output logic [BFAP_AW-1:0] reset_vector
);

   bfap_state_t st;
   bfap_state_t next_st;

   // section of a word address
   function automatic logic in_boot(
      input logic [BFAP_AW-1:0] a,
      input logic [BFAP_AW-1:0] b
   );
      in_boot = (a >= b);
   endfunction

   // byte-lane merge of a write word
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      lane_merge = r;
   endfunction

   logic req_go;
   logic wr_go;
   logic rd_go;
   logic pc_boot;
   logic tgt_boot;
   logic app_rd_lock;
   logic app_wr_lock;
   logic boot_rd_lock;
   logic boot_wr_lock;
   logic [31:0] cfg_word;
   logic [31:0] cfg_new;
   logic [2:0] stat_set;

   always_comb begin
      next_st = st;
      req_go = wb_cyc_i && wb_stb_i && !st.ack;
      wr_go = req_go && wb_we_i;
      rd_go = req_go && !wb_we_i;
      pc_boot = in_boot(cpu_req.pc, st.bound);
      tgt_boot = in_boot(cpu_req.addr, st.bound);
      // zero means programmed; general lock bits are never consulted here
      app_rd_lock = !st.lock[`BFAP_LOCK_APP_HI];
      app_wr_lock = !st.lock[`BFAP_LOCK_APP_LO];
      boot_rd_lock = !st.lock[`BFAP_LOCK_BOOT_HI];
      boot_wr_lock = !st.lock[`BFAP_LOCK_BOOT_LO];
      cfg_word = '0;
      cfg_word[BFAP_AW-1:0] = st.bound;
      cfg_word[`BFAP_CFG_IVEC_BIT] = st.ivec_boot;
      cfg_new = lane_merge(cfg_word, wb_dat_i, wb_sel_i);
      stat_set = '0;

      // cpu side: one answer pulse per request
      next_st.resp = '0;
      if (cpu_req.valid) begin
         next_st.resp.done = 1'b1;
         next_st.resp.op = cpu_req.op;
         case (cpu_req.op)
            BFAP_OP_LOAD: begin
               if (pc_boot && !tgt_boot && app_rd_lock) begin
                  next_st.resp.denied = 1'b1;
               end else if (!pc_boot && tgt_boot && boot_rd_lock) begin
                  next_st.resp.denied = 1'b1;
               end else begin
                  next_st.resp.granted = 1'b1;
               end
            end
            BFAP_OP_FILL: begin
               next_st.resp.granted = pc_boot;
               next_st.resp.denied = !pc_boot;
            end
            BFAP_OP_ERASE, BFAP_OP_WRITE: begin
               if (!pc_boot) begin
                  next_st.resp.denied = 1'b1;
               end else if (tgt_boot ? boot_wr_lock : app_wr_lock) begin
                  next_st.resp.denied = 1'b1;
               end else begin
                  next_st.resp.granted = 1'b1;
                  next_st.resp.prog_start = 1'b1;
               end
            end
            BFAP_OP_LOCKSET: begin
               if (pc_boot) begin
                  next_st.resp.granted = 1'b1;
                  // only clears bits, so locks move toward programmed
                  next_st.lock = st.lock & cpu_req.data[5:0];
               end else begin
                  next_st.resp.denied = 1'b1;
               end
            end
            default: begin
               next_st.resp.denied = 1'b1;
            end
         endcase
         if (next_st.resp.denied) begin
            if (cpu_req.op == BFAP_OP_LOAD) begin
               stat_set[`BFAP_STAT_RD_DENY] = 1'b1;
            end else begin
               stat_set[`BFAP_STAT_WR_DENY] = 1'b1;
            end
            if (!pc_boot && cpu_req.op != BFAP_OP_LOAD) begin
               stat_set[`BFAP_STAT_APP_STORE] = 1'b1;
            end
         end
      end

      // wishbone: ack one cycle after the request, dropped next cycle
      next_st.ack = req_go;
      next_st.rdat = '0;
      if (rd_go) begin
         case (wb_adr_i)
            `BFAP_OFS_LOCK: begin
               next_st.rdat[5:0] = st.lock;
            end
            `BFAP_OFS_FUSE: begin
               next_st.rdat[0] = st.fuse;
            end
            `BFAP_OFS_CFG: begin
               next_st.rdat = cfg_word;
            end
            `BFAP_OFS_CTRL: begin
               next_st.rdat[1] = ext_prog_mode;
            end
            `BFAP_OFS_STAT: begin
               next_st.rdat[2:0] = st.stat;
            end
            default: begin
               next_st.rdat = '0;
            end
         endcase
      end
      if (wr_go) begin
         case (wb_adr_i)
            `BFAP_OFS_LOCK: begin
               if (ext_prog_mode && wb_sel_i[0]) begin
                  next_st.lock = next_st.lock & wb_dat_i[5:0];
               end
            end
            `BFAP_OFS_FUSE: begin
               if (ext_prog_mode && wb_sel_i[0]) begin
                  next_st.fuse = wb_dat_i[0];
               end
            end
            `BFAP_OFS_CFG: begin
               next_st.bound = cfg_new[BFAP_AW-1:0];
               next_st.ivec_boot = cfg_new[`BFAP_CFG_IVEC_BIT];
            end
            `BFAP_OFS_CTRL: begin
               if (ext_prog_mode && wb_sel_i[0] && wb_dat_i[`BFAP_CTRL_ERASE_BIT]) begin
                  next_st.lock = `BFAP_LOCK_RESET;
               end
            end
            `BFAP_OFS_STAT: begin
               if (wb_sel_i[0]) begin
                  next_st.stat = st.stat & ~wb_dat_i[2:0];
               end
            end
            default: begin
               next_st.stat = next_st.stat;
            end
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_st.stat = next_st.stat | stat_set;

      // interrupt masking follows the executing section
      next_st.irq_mask = 1'b0;
      if (st.ivec_boot && !in_boot(cpu_req.pc, st.bound) && app_rd_lock) begin
         next_st.irq_mask = 1'b1;
      end
      if (!st.ivec_boot && in_boot(cpu_req.pc, st.bound) && boot_rd_lock) begin
         next_st.irq_mask = 1'b1;
      end

      // reset vector from the boot reset fuse
      next_st.rst_vec = st.fuse ? '0 : st.bound;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st.lock <= `BFAP_LOCK_RESET;
         st.fuse <= `BFAP_FUSE_RESET;
         st.bound <= BOUND_RESET;
         st.ivec_boot <= 1'b0;
         st.stat <= '0;
         st.resp <= '0;
         st.irq_mask <= 1'b0;
         st.rst_vec <= '0;
         st.ack <= 1'b0;
         st.rdat <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.rdat;
   assign wb_ack_o = st.ack;
   assign cpu_resp = st.resp;
   assign irq_mask = st.irq_mask;
   assign reset_vector = st.rst_vec;

endmodule
`default_nettype wire

// *** bench/bfap_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module bfap_chk import bfap_pkg::*; #(
   parameter logic [BFAP_AW-1:0] BOUND_RESET = 16'h1C00
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bus handshake
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // cpu side
   input wire bfap_req_t cpu_req,
   input wire bfap_resp_t cpu_resp,
   input wire logic [BFAP_AW-1:0] reset_vector
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic pc_boot;
   logic ld_same;
   assign pc_boot = cpu_req.pc >= BOUND_RESET;
   assign ld_same = cpu_req.valid && cpu_req.op == BFAP_OP_LOAD
      && pc_boot == (cpu_req.addr >= BOUND_RESET);
   sequence s_wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_app_store;
      cpu_req.valid && !pc_boot && cpu_req.op inside {BFAP_OP_ERASE, BFAP_OP_WRITE};
   endsequence
   sequence s_boot_fill;
      cpu_req.valid && pc_boot && cpu_req.op == BFAP_OP_FILL;
   endsequence
   a_boot_fill_ok: assert property (s_boot_fill |=> cpu_resp.granted && !cpu_resp.denied)
      else $error("buffer fill from boot section refused");
   a_resp_one_way: assert property (cpu_resp.done |-> cpu_resp.granted != cpu_resp.denied)
      else $error("answer not exactly one of granted or denied");
   a_wb_ack_next: assert property (s_wb_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack wider than one cycle");
   a_resp_done_op: assert property (cpu_req.valid |=> cpu_resp.done && cpu_resp.op == $past(cpu_req.op))
      else $error("request not answered next cycle");
   a_app_store_deny: assert property (s_app_store |=> cpu_resp.denied && !cpu_resp.prog_start)
      else $error("store from app section not refused");
   a_same_sec_load: assert property (ld_same |=> cpu_resp.granted && !cpu_resp.denied)
      else $error("load inside own section refused");
   a_idle_quiet: assert property (!cpu_req.valid |=> !cpu_resp.done && !cpu_resp.prog_start)
      else $error("answer without request");
   a_vec_choice: assert property (reset_vector == 16'h0000 || reset_vector == BOUND_RESET)
      else $error("reset vector neither zero nor boundary");
   a_prog_granted: assert property (cpu_resp.prog_start |-> cpu_resp.granted && !cpu_resp.denied)
      else $error("programming started while refused");
endmodule
`default_nettype wire

// *** bench/bfap_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module bfap_cpu_model import bfap_pkg::*; (
   // clock
   input wire logic clock,
   // request and answer
   output var bfap_req_t cpu_req,
   input wire bfap_resp_t cpu_resp
);
   initial cpu_req = '0;
   task automatic jump(input logic [BFAP_AW-1:0] pc);
      @(posedge clock);
      cpu_req.pc <= pc;
   endtask
   task automatic exec(input bfap_op_t op, input logic [BFAP_AW-1:0] addr,
         input logic [7:0] data, output bfap_resp_t resp);
      int n;
      @(posedge clock);
      cpu_req <= '{1'b1, op, cpu_req.pc, addr, data};
      @(posedge clock);
      cpu_req <= '{1'b0, op, cpu_req.pc, ~addr, ~data};
      resp = '0;
      for (n = 0; n < 8 && resp.done !== 1'b1; n++) begin
         @(negedge clock);
         resp = cpu_resp;
      end
   endtask
endmodule
`default_nettype wire

// *** bench/tb_boot_flash_access_protection.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bfap_map.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_boot_flash_access_protection import bfap_pkg::*; ;
   localparam logic [15:0] BND = 16'h1C00;
   logic clock, rst_n, cyc, stb, we, ack, ext, irq, s;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q;
   logic [15:0] rvec, tg, ot;
   logic [1:0] f;
   logic [5:0] lk;
   bfap_req_t req;
   bfap_resp_t resp, r;
   int n_fail = 0, checked = 0, c;
   bfap_top #(.BOUND_RESET(BND)) i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .ext_prog_mode(ext), .cpu_req(req),
      .cpu_resp(resp), .irq_mask(irq), .reset_vector(rvec));
   bfap_cpu_model i_cpu (.clock(clock), .cpu_req(req), .cpu_resp(resp));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic finish_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 8);
      q = rdat;
      {cyc, stb} <= 2'b00;
      if (ack !== 1'b1) begin
         n_fail++;
         $display("[FAIL] bus ack timeout");
         finish_test();
      end
   endtask
   task automatic cpu(input logic [15:0] pc, input bfap_op_t op, input logic [15:0] a,
         input logic [7:0] d);
      i_cpu.jump(pc);
      i_cpu.exec(op, a, d, r);
      if (r.done !== 1'b1) begin
         n_fail++;
         $display("[FAIL] cpu answer timeout");
         finish_test();
      end
   endtask
   initial begin
      {cyc, stb, we, adr, wdat, ext} = '0;
      rst_n = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      `CHK("reset vector", 16'h0000, rvec)
      wb(1'b1, `BFAP_OFS_LOCK, 32'h0);
      wb(1'b0, `BFAP_OFS_LOCK, 32'h0);
      `CHK("lock", 32'h3F, q)
      wb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, q)
      wb(1'b1, `BFAP_OFS_FUSE, 32'h0);
      @(negedge clock);
      `CHK("fuse locked", 16'h0000, rvec)
      ext <= 1'b1;
      for (c = 0; c < 8; c++) begin
         s = c[2];
         f = c[1:0];
         lk = s ? {f, 4'hC} : {2'b11, f, 2'b00};
         tg = s ? BND : 16'h0000;
         ot = s ? 16'h0000 : BND;
         wb(1'b1, `BFAP_OFS_CTRL, 32'h1);
         wb(1'b1, `BFAP_OFS_LOCK, {26'h0, lk});
         wb(1'b1, `BFAP_OFS_CFG, {15'h0, !s, BND});
         cpu(BND, BFAP_OP_WRITE, tg, 8'hFF);
         `CHK("store denied", !f[0], r.denied)
         `CHK("prog start", f[0], r.prog_start)
         cpu(ot, BFAP_OP_LOAD, tg, 8'hFF);
         `CHK("load denied", !f[1], r.denied)
         i_cpu.jump(tg);
         repeat (2) @(negedge clock);
         `CHK("irq mask", !f[1], irq)
      end
      wb(1'b1, `BFAP_OFS_CTRL, 32'h1);
      cpu(BND, BFAP_OP_LOCKSET, 16'h0001, 8'hEB);
      wb(1'b0, `BFAP_OFS_LOCK, 32'h0);
      `CHK("lockset", 32'h2B, q)
      cpu(16'h0000, BFAP_OP_LOCKSET, 16'h0001, 8'hC0);
      `CHK("app lockset", 1'b1, r.denied)
      cpu(16'h0010, BFAP_OP_ERASE, 16'h0000, 8'hFF);
      `CHK("app erase", 1'b1, r.denied)
      cpu(BND, BFAP_OP_FILL, BND, 8'hFF);
      `CHK("boot fill", 1'b1, r.granted)
      cpu(16'h0000, BFAP_OP_LOAD, 16'h0004, 8'hFF);
      `CHK("own load", 1'b1, r.granted)
      wb(1'b1, `BFAP_OFS_FUSE, 32'h0);
      repeat (2) @(negedge clock);
      `CHK("boot vector", BND, rvec)
      finish_test();
   end
endmodule
bind bfap_top bfap_chk #(.BOUND_RESET(BOUND_RESET)) i_chk (.clock(clock), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_req(cpu_req),
   .cpu_resp(cpu_resp), .reset_vector(reset_vector));
`default_nettype wire
